// [rtl/gpcfg_top.sv]
/*
 gpcfg_top: mode decode, alternate source selection, forced debug and
 regulator functions and boot select sampling for 24 pins, with apb registers.
 assumes presetn is the merged full-chip reset and pclk is the fast oscillator;
 peripheral and debug core signals are on pclk, pad and tool inputs are not.
*/
module gpcfg_top
    import gpcfg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire gpcfg_pkg::gpcfg_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pads
    input wire logic [gpcfg_pkg::NPINS-1:0] pad_in,
    output gpcfg_pkg::gpcfg_pad_type pad,
    // peripheral sources
    input wire logic [3:0] timer2_channel_out,
    input wire logic [gpcfg_pkg::NPINS-1:0] serial_alt_en,
    input wire logic [gpcfg_pkg::NPINS-1:0] serial_alt_out,
    input wire logic reg_enable_level,
    // debug tool and debug core
    input wire logic debug_powerup_request,
    input wire logic serial_wire_mode,
    input wire logic chip_reset_hold,
    input wire logic debug_data_out,
    input wire logic swdio_out,
    input wire logic swdio_drive,
    output logic debug_reset_in,
    output logic debug_data_in,
    output logic debug_mode_select_in,
    // boot
    output logic boot_loader_sel
);
    import gpcfg_pkg::*;

    typedef struct packed {
        logic [NPINS-1:0][3:0] cfg;
        logic [NPINS-1:0] out_data;
        logic [3:0] t2_route;
        logic [3:0] t2_en;
        logic ext_reg_en;
        logic dbg_dis;
        logic dbg_forced;
        logic boot_done;
        logic boot_cap;
        logic boot_ldr;
        logic [9:0] boot_cnt;
        logic [NPINS-1:0] s1;
        logic [NPINS-1:0] s2;
        logic [NPINS-1:0] s3;
        logic [NPINS-1:0] pin_lvl;
        logic [2:0] c1;
        logic [2:0] c2;
        logic [2:0] c3;
        logic [2:0] ctl_lvl;
        logic [2:0] dbg_in;
        gpcfg_pad_type pad;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gpcfg_state_type;

    gpcfg_state_type r;
    gpcfg_state_type r_nxt;
    logic dbg_active;
    logic serial_mode;
    logic hold_lvl;
    logic [NPINS-1:0] in_val;

    // returns {oe_n, out, pull_up, pull_dn, analog} for one pin
    function automatic logic [4:0] pin_drive(input logic [3:0] mode, input logic dat,
                                             input logic alt);
        logic [4:0] d;
        d = 5'h10;
        // RULE_04 RULE_05 RULE_06 input and output modes
        case (mode)
            MODE_ANALOG: d = 5'h11;
            MODE_IN_PULL: d = {1'b1, 1'b0, dat, ~dat, 1'b0};
            MODE_OUT_PP: d = {1'b0, dat, 3'h0};
            // open drain only sinks a low
            MODE_OUT_OD: d = {dat, 1'b0, 3'h0};
            MODE_ALT_PP: d = {1'b0, alt, 3'h0};
            MODE_ALT_OD: d = {alt, 1'b0, 3'h0};
            default: d = 5'h10;
        endcase
        return d;
    endfunction : pin_drive

    // three-stage pad sampling; a change counts once stages two and three agree
    function automatic logic filt(input logic a, input logic b, input logic prev);
        return (a == b) ? a : prev;
    endfunction : filt

    assign dbg_active = r.ctl_lvl[0];
    assign serial_mode = r.ctl_lvl[1];
    assign hold_lvl = r.ctl_lvl[2];

    // RULE_03 analog reads one
    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            in_val[i] = (r.cfg[i] == MODE_ANALOG) ? 1'b1 : r.pin_lvl[i];
        end
    end

    always_comb
    begin
        logic [4:0] d;
        logic alt;
        logic [4:0] tp;
        logic [5:0] idx;
        logic setup;
        d = '0;
        alt = 1'b0;
        tp = '0;
        idx = '0;
        setup = apb_req.psel & ~apb_req.penable;
        r_nxt = r;

        // pad and tool input synchronisers
        r_nxt.s1 = pad_in;
        r_nxt.s2 = r.s1;
        r_nxt.s3 = r.s2;
        r_nxt.c1 = {chip_reset_hold, serial_wire_mode, debug_powerup_request};
        r_nxt.c2 = r.c1;
        r_nxt.c3 = r.c2;
        for (int i = 0; i < NPINS; i++)
        begin
            r_nxt.pin_lvl[i] = filt(r.s2[i], r.s3[i], r.pin_lvl[i]);
        end
        for (int i = 0; i < 3; i++)
        begin
            r_nxt.ctl_lvl[i] = filt(r.c2[i], r.c3[i], r.ctl_lvl[i]);
        end

        // per pin mode decode
        for (int i = 0; i < NPINS; i++)
        begin
            // RULE_12 no source gives zero
            alt = 1'b0;
            // RULE_09 serial source select
            if (serial_alt_en[i])
            begin
                alt = serial_alt_out[i];
            end
            for (int ch = 0; ch < 4; ch++)
            begin
                // RULE_11 channel pin routing
                tp = r.t2_route[ch] ? T2_PIN_B[ch] : T2_PIN_A[ch];
                // RULE_10 timer over serial
                if (r.t2_en[ch] && (tp == 5'(i)))
                begin
                    alt = timer2_channel_out[ch];
                end
            end
            // RULE_01 one code per pin
            // RULE_07 RULE_08 alternate drive
            d = pin_drive(r.cfg[i], r.out_data[i], alt);
            {r_nxt.pad.oe_n[i], r_nxt.pad.out[i], r_nxt.pad.pull_up[i],
             r_nxt.pad.pull_dn[i], r_nxt.pad.analog[i]} = d;
        end

        // RULE_13 forced functions override
        // RULE_14 regulator enable on a7
        if (r.ext_reg_en)
        begin
            r_nxt.pad.oe_n[PIN_A7] = reg_enable_level;
            r_nxt.pad.out[PIN_A7] = 1'b0;
            r_nxt.pad.pull_up[PIN_A7] = 1'b0;
            r_nxt.pad.pull_dn[PIN_A7] = 1'b0;
            r_nxt.pad.analog[PIN_A7] = 1'b0;
        end
        // RULE_15 debug pin roles
        if (!r.dbg_dis)
        begin
            r_nxt.pad.oe_n[PIN_C0] = 1'b1;
            r_nxt.pad.pull_up[PIN_C0] = 1'b1;
            r_nxt.pad.oe_n[PIN_C2] = 1'b0;
            r_nxt.pad.out[PIN_C2] = debug_data_out;
            r_nxt.pad.pull_up[PIN_C2] = 1'b0;
            r_nxt.pad.oe_n[PIN_C3] = 1'b1;
            r_nxt.pad.pull_up[PIN_C3] = 1'b1;
            // RULE_16 mode chosen by the tool
            r_nxt.pad.oe_n[PIN_C4] = serial_mode ? ~swdio_drive : 1'b1;
            r_nxt.pad.out[PIN_C4] = swdio_out;
            r_nxt.pad.pull_up[PIN_C4] = ~serial_mode;
            for (int k = 0; k < 4; k++)
            begin
                tp = (k == 0) ? 5'(PIN_C0) : 5'(PIN_C2 + k - 1);
                r_nxt.pad.pull_dn[tp] = 1'b0;
                r_nxt.pad.analog[tp] = 1'b0;
            end
        end
        r_nxt.dbg_in = r.dbg_dis ? 3'h7 :
            {r.pin_lvl[PIN_C4], r.pin_lvl[PIN_C3], r.pin_lvl[PIN_C0]};

        // RULE_22 boot select window
        if (!r.boot_done)
        begin
            r_nxt.pad.oe_n[PIN_A5] = 1'b1;
            r_nxt.pad.pull_up[PIN_A5] = 1'b1;
            r_nxt.pad.pull_dn[PIN_A5] = 1'b0;
            r_nxt.pad.analog[PIN_A5] = 1'b0;
            r_nxt.boot_cnt = r.boot_cnt + 10'h001;
            if (r.boot_cnt == BOOT_LAST)
            begin
                // RULE_24 keep sampled level
                r_nxt.boot_done = 1'b1;
                r_nxt.boot_cap = r.pin_lvl[PIN_A5];
                // RULE_23 low picks loader
                r_nxt.boot_ldr = ~r.pin_lvl[PIN_A5];
            end
        end

        // apb: answer is prepared in setup, so the access phase never waits
        r_nxt.pready = setup;
        r_nxt.pslverr = 1'b0;
        r_nxt.prdata = '0;
        idx = apb_req.paddr[7:2];
        if (setup)
        begin
            if (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > OFF_LAST)
            begin
                r_nxt.pslverr = 1'b1;
            end
            // RULE_02 low and high halves
            else if (apb_req.paddr < OFF_OUT_A)
            begin
                r_nxt.prdata[15:0] = r.cfg[idx * 4 +: 4];
            end
            else if (apb_req.paddr < OFF_IN_A)
            begin
                r_nxt.prdata[7:0] = r.out_data[(idx - 6) * 8 +: 8];
            end
            else if (apb_req.paddr < OFF_DBG_CFG)
            begin
                r_nxt.prdata[7:0] = in_val[(idx - 9) * 8 +: 8];
            end
            else if (apb_req.paddr == OFF_DBG_CFG)
            begin
                r_nxt.prdata[BIT_EXT_REG_EN] = r.ext_reg_en;
                r_nxt.prdata[BIT_DEBUG_DIS] = r.dbg_dis;
            end
            else if (apb_req.paddr == OFF_DBG_STAT)
            begin
                r_nxt.prdata[BIT_FORCED] = r.dbg_forced;
                r_nxt.prdata[BIT_BOOT_CAP] = r.boot_cap;
                r_nxt.prdata[BIT_DBG_ACTIVE] = dbg_active;
                r_nxt.prdata[BIT_SERIAL_WIRE] = serial_mode;
            end
            else if (apb_req.paddr == OFF_T2_ROUTE)
            begin
                r_nxt.prdata[BIT_T2_ROUTE_LO +: 4] = r.t2_route;
            end
            else
            begin
                r_nxt.prdata[3:0] = r.t2_en;
            end
        end

        // writes land at the access edge, where pready is high
        if (apb_req.psel && apb_req.penable && apb_req.pwrite && r.pready && !r.pslverr)
        begin
            if (apb_req.paddr < OFF_OUT_A)
            begin
                r_nxt.cfg[idx * 4 +: 4] = apb_req.pwdata[15:0];
            end
            else if (apb_req.paddr < OFF_IN_A)
            begin
                r_nxt.out_data[(idx - 6) * 8 +: 8] = apb_req.pwdata[7:0];
            end
            else if (apb_req.paddr == OFF_DBG_CFG)
            begin
                r_nxt.ext_reg_en = apb_req.pwdata[BIT_EXT_REG_EN];
                // RULE_17 refused while active
                r_nxt.dbg_dis = apb_req.pwdata[BIT_DEBUG_DIS] & ~(dbg_active & ~r.dbg_dis);
            end
            else if (apb_req.paddr == OFF_DBG_STAT)
            begin
                if (apb_req.pwdata[BIT_FORCED])
                begin
                    r_nxt.dbg_forced = 1'b0;
                end
            end
            else if (apb_req.paddr == OFF_T2_ROUTE)
            begin
                r_nxt.t2_route = apb_req.pwdata[BIT_T2_ROUTE_LO +: 4];
            end
            else if (apb_req.paddr == OFF_T2_ENABLE)
            begin
                r_nxt.t2_en = apb_req.pwdata[3:0];
            end
        end
        // RULE_18 RULE_19 tool reclaims debug pins
        if (hold_lvl && dbg_active)
        begin
            r_nxt.dbg_dis = 1'b0;
            if (r.dbg_dis)
            begin
                r_nxt.dbg_forced = 1'b1;
            end
        end
        else if (dbg_active && !r.dbg_dis)
        begin
            r_nxt.dbg_dis = 1'b0;
        end
    end

    // RULE_20 RULE_21 full chip defaults
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.cfg <= {NPINS{MODE_IN_FLOAT}};
            r.ext_reg_en <= 1'b1;
            r.pad.oe_n <= '1;
            r.pad.pull_up <= RST_PULL_UP;
            r.dbg_in <= 3'h7;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign pad = r.pad;
    assign {debug_mode_select_in, debug_data_in, debug_reset_in} = r.dbg_in;
    assign boot_loader_sel = r.boot_ldr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_analog_pin_off: assert property (r.cfg[13] == MODE_ANALOG |=> // RULE_03
        r.pad.oe_n[13] && r.pad.analog[13] && !r.pad.pull_up[13])
        else $error("analog pin drives");
    a_float_input: assert property (r.cfg[1] == MODE_IN_FLOAT |=> // RULE_04
        r.pad.oe_n[1] && !r.pad.pull_up[1] && !r.pad.pull_dn[1]) else $error("float input bad");
    a_pull_select: assert property (r.cfg[13] == MODE_IN_PULL |=> // RULE_05
        r.pad.pull_up[13] == $past(r.out_data[13]) && r.pad.pull_dn[13] != r.pad.pull_up[13])
        else $error("pull select wrong");
    a_push_pull_out: assert property (r.cfg[13] == MODE_OUT_PP |=> // RULE_06
        !r.pad.oe_n[13] && r.pad.out[13] == $past(r.out_data[13]))
        else $error("push-pull wrong");
    a_timer_wins: assert property (r.t2_en[0] && !r.t2_route[0] && r.cfg[0] == MODE_ALT_PP // RULE_10
        |=> r.pad.out[0] == $past(timer2_channel_out[0])) else $error("timer not first");
    a_no_source_zero: assert property (r.cfg[6] == MODE_ALT_PP && !serial_alt_en[6] // RULE_12
        |=> !r.pad.oe_n[6] && !r.pad.out[6]) else $error("alt without source");
    a_regen_forced: assert property (r.ext_reg_en |=> // RULE_14
        r.pad.oe_n[PIN_A7] == $past(reg_enable_level) && !r.pad.out[PIN_A7])
        else $error("a7 not regulator enable");
    a_disable_refused: assert property (dbg_active && !r.dbg_dis |=> !r.dbg_dis) // RULE_17
        else $error("debug disable set while active");
    a_boot_pullup: assert property (!r.boot_done |=> r.pad.pull_up[PIN_A5]) // RULE_22
        else $error("a5 not pulled during boot window");
    a_boot_capture: assert property ($rose(r.boot_done) |-> // RULE_24
        r.boot_cap == $past(r.pin_lvl[PIN_A5]) && r.boot_ldr == !r.boot_cap)
        else $error("boot level not captured");

    c_serial_alt: cover property (r.cfg[13] == MODE_ALT_OD && serial_alt_en[13]);
    c_boot_loader: cover property ($rose(r.boot_ldr));
    c_forced_debug: cover property ($rose(r.dbg_forced));
    c_swd_mode: cover property (serial_mode && !r.dbg_dis && !r.pad.oe_n[PIN_C4]);
endmodule : gpcfg_top

// [rtl/gpcfg_pkg.sv]
/*
 gpcfg_pkg: register offsets, mode codes, reset values, pin numbering and the
 carrier structs of the pin configuration block.
 assumes a 32-bit apb bus, pins numbered 0..23 as port a, b, c bits 0..7.
*/
// Operation
// RULE_01 - every pin has its own 4-bit mode code
// RULE_02 - low config register holds pins 3..0, high register pins 7..4
// RULE_03 - mode 0x0 is analog; input data reads as 1
// RULE_04 - mode 0x4 is floating input, driver off, no pull
// RULE_05 - mode 0x8 is pulled input; output bit picks pull-up or pull-down
// RULE_06 - mode 0x1 push-pull, mode 0x5 open-drain from output data bit
// RULE_07 - mode 0x9 push-pull driven by a peripheral output
// RULE_08 - mode 0xD open-drain driven by a peripheral output
// RULE_09 - extra select registers decide which peripheral drives a shared pin
// RULE_10 - enabled timer 2 channel beats the serial controller output
// RULE_11 - route bits 4..7 put each timer 2 channel on port a or port b
// RULE_12 - alternate mode without a peripheral source drives 0
// RULE_13 - forced functions override mode codes from reset until released
// RULE_14 - pin a7 is open-drain regulator enable while enable bit is set
// RULE_15 - debug pins c0, c2, c3, c4 forced to their debug roles
// RULE_16 - debug port starts four-wire; only the tool picks serial wire
// RULE_17 - debug-disable frees debug pins; refused while debug is active
// RULE_18 - tool active during reset restores debug pins and sets forced flag
// RULE_19 - debug counts as active while the powerup request is high
// RULE_20 - any full-chip reset source applies the reset defaults
// RULE_21 - reset: all floating inputs, regulator enable set, disable clear
// RULE_22 - pin a5 pulled-up input for 512 clocks, then boot level sampled
// RULE_23 - sampled low selects the serial boot loader, high normal boot
// RULE_24 - a5 then floats; a status bit keeps the sampled level
package gpcfg_pkg;
    localparam int NPINS = 24;
    localparam logic [7:0] OFF_CFG_A_LO = 8'h00;
    localparam logic [7:0] OFF_OUT_A = 8'h18;
    localparam logic [7:0] OFF_IN_A = 8'h24;
    localparam logic [7:0] OFF_DBG_CFG = 8'h30;
    localparam logic [7:0] OFF_DBG_STAT = 8'h34;
    localparam logic [7:0] OFF_T2_ROUTE = 8'h38;
    localparam logic [7:0] OFF_T2_ENABLE = 8'h3C;
    localparam logic [7:0] OFF_LAST = 8'h3C;
    // debug config, debug status and timer 2 route fields
    localparam int BIT_EXT_REG_EN = 4;
    localparam int BIT_DEBUG_DIS = 5;
    localparam int BIT_FORCED = 0;
    localparam int BIT_BOOT_CAP = 1;
    localparam int BIT_DBG_ACTIVE = 2;
    localparam int BIT_SERIAL_WIRE = 3;
    localparam int BIT_T2_ROUTE_LO = 4;
    // mode codes
    localparam logic [3:0] MODE_ANALOG = 4'h0;
    localparam logic [3:0] MODE_OUT_PP = 4'h1;
    localparam logic [3:0] MODE_IN_FLOAT = 4'h4;
    localparam logic [3:0] MODE_OUT_OD = 4'h5;
    localparam logic [3:0] MODE_IN_PULL = 4'h8;
    localparam logic [3:0] MODE_ALT_PP = 4'h9;
    localparam logic [3:0] MODE_ALT_OD = 4'hD;
    // pin numbers of the forced and routed functions
    localparam int PIN_A5 = 5;
    localparam int PIN_A7 = 7;
    localparam int PIN_C0 = 16;
    localparam int PIN_C2 = 18;
    localparam int PIN_C3 = 19;
    localparam int PIN_C4 = 20;
    localparam logic [3:0][4:0] T2_PIN_A = {5'h02, 5'h01, 5'h03, 5'h00};
    localparam logic [3:0][4:0] T2_PIN_B = {5'h0C, 5'h0B, 5'h0A, 5'h09};
    // boot select delay in fast oscillator clocks, which also clock this block
    localparam int BOOT_DELAY_CLKS = 512;
    localparam logic [9:0] BOOT_LAST = 10'(BOOT_DELAY_CLKS - 1);
    localparam logic [NPINS-1:0] RST_PULL_UP = 24'h19_0020;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } gpcfg_apb_req_type;

    typedef struct packed {
        logic [NPINS-1:0] out;
        logic [NPINS-1:0] oe_n;
        logic [NPINS-1:0] pull_up;
        logic [NPINS-1:0] pull_dn;
        logic [NPINS-1:0] analog;
    } gpcfg_pad_type;
endpackage : gpcfg_pkg

// [testbench/gpcfg_board.sv]
/*
 gpcfg_board: board side of the 24 pins, turns pad drive, pulls and board
 drivers into the level each pin shows.
 assumes the bench sets the board drive, level and external pull-up masks.
*/
module gpcfg_board (
    // pads from the block
    input wire gpcfg_pkg::gpcfg_pad_type pad,
    // board drivers and resistors
    input wire logic [gpcfg_pkg::NPINS-1:0] brd_en,
    input wire logic [gpcfg_pkg::NPINS-1:0] brd_lvl,
    input wire logic [gpcfg_pkg::NPINS-1:0] brd_pu,
    // pin levels back to the block
    output logic [gpcfg_pkg::NPINS-1:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpcfg_pkg::*;
    logic flip = 1'b0;

    // floating pins wander, so nothing leans on a simulator-chosen level
    always #37 flip = ~flip;

    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            pad_in[i] = !pad.oe_n[i] ? pad.out[i] :
                brd_en[i] ? brd_lvl[i] :
                (pad.pull_up[i] | brd_pu[i]) ? 1'b1 :
                pad.pull_dn[i] ? 1'b0 : flip ^ i[0];
        end
    end
endmodule : gpcfg_board

// [testbench/gpcfg_tb_top.sv]
/*
 gpcfg_tb_top: self-checking bench for the pin configuration block.
 assumes gpcfg_top with zero-wait apb and the board model gpcfg_board.
*/
module gpcfg_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gpcfg_pkg::*;
    logic pclk;
    logic presetn = 1'b0;
    gpcfg_apb_req_type apb_req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NPINS-1:0] pad_in;
    gpcfg_pad_type pad;
    logic [3:0] tmr = 4'h0;
    logic [NPINS-1:0] sa_en = '0;
    logic [NPINS-1:0] sa_out = '0;
    logic [NPINS-1:0] brd_en = '0;
    logic [NPINS-1:0] brd_lvl = '0;
    logic [NPINS-1:0] brd_pu = '0;
    logic reg_lvl = 1'b1;
    logic dbg_req = 1'b0;
    logic sw_mode = 1'b0;
    logic rst_hold = 1'b0;
    logic dbg_do = 1'b0;
    logic swd_o = 1'b0;
    logic swd_drv = 1'b0;
    logic dbg_rst;
    logic dbg_di;
    logic dbg_ms;
    logic boot_sel;
    logic [31:0] rd;
    logic err;
    logic [31:0] rnd = 32'hcfe5_cfc5;
    logic [4:0] s;
    logic [3:0] m;
    logic b;
    logic v;
    logic e;
    int failures = 0;
    int num_checks = 0;
    int pa[4] = '{0, 3, 1, 2};
    int pb[4] = '{9, 10, 11, 12};
    logic [3:0] modes[7] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hD};

    gpcfg_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad(pad),
        .timer2_channel_out(tmr), .serial_alt_en(sa_en), .serial_alt_out(sa_out),
        .reg_enable_level(reg_lvl), .debug_powerup_request(dbg_req),
        .serial_wire_mode(sw_mode), .chip_reset_hold(rst_hold), .debug_data_out(dbg_do),
        .swdio_out(swd_o), .swdio_drive(swd_drv), .debug_reset_in(dbg_rst),
        .debug_data_in(dbg_di), .debug_mode_select_in(dbg_ms), .boot_loader_sel(boot_sel));
    gpcfg_board u_brd (.pad(pad), .brd_en(brd_en), .brd_lvl(brd_lvl), .brd_pu(brd_pu),
        .pad_in(pad_in));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // expected {analog, pull-up, pull-down, sourcing, sinking}
    function automatic logic [4:0] exp_pad(input logic [3:0] md, input logic o, input logic a);
        case (md)
            4'h0: return 5'h10;
            4'h8: return {1'b0, o, !o, 2'b0};
            4'h1: return {3'b0, o, !o};
            4'h5: return {4'b0, !o};
            4'h9: return {3'b0, a, !a};
            4'hD: return {4'b0, !a};
            default: return 5'h0;
        endcase
    endfunction : exp_pad

    function automatic logic exp_lvl(input logic [3:0] md, input logic o, input logic a,
        input logic p);
        case (md)
            4'h0: return 1'b1;
            4'h1, 4'h5: return o;
            4'h9, 4'hD: return a;
            default: return p;
        endcase
    endfunction : exp_lvl

    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : wt

    // answer is taken at the rising edge that ends the access, never mid-cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
        if (n >= 20)
            failures++;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd & mk, x);
    endtask : rdc

    task automatic do_reset(input logic lvl);
        presetn <= 1'b0;
        brd_en[5] <= 1'b1;
        brd_lvl[5] <= lvl;
        wt(3);
        chk(32'(pad.oe_n), 32'h00ff_ffff);
        chk(32'(pad.pull_up[5]), 32'h1);
        @(posedge pclk);
        presetn <= 1'b1;
        wt(500);
        chk(32'({pad.pull_up[5], boot_sel}), 32'h2);
        wt(20);
        chk(32'({pad.pull_up[5], boot_sel}), 32'(!lvl));
        @(posedge pclk);
        brd_en[5] <= 1'b0;
        rdc(8'h34, 32'h2, 32'({lvl, 1'b0}));
        rdc(8'h00, 32'hffff, 32'h4444);
        rdc(8'h14, 32'hffff, 32'h4444);
        rdc(8'h30, 32'h30, 32'h10);
    endtask : do_reset

    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        conclude();
    end

    initial
    begin
        do_reset(1'b0);
        apb(1'b1, 8'h04, 32'h1444);
        apb(1'b1, 8'h18, 32'h80);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge pclk);
            reg_lvl <= k[0];
            wt(2);
            chk(32'(pad.oe_n[7]), 32'(k[0]));
        end
        apb(1'b1, 8'h30, 32'h0);
        wt(1);
        chk(32'({pad.oe_n[7], pad.out[7]}), 32'h1);
        @(posedge pclk);
        rnd = lfsr(rnd);
        dbg_do <= rnd[0];
        brd_en[20:16] <= 5'h1b;
        brd_lvl[20:16] <= rnd[5:1];
        wt(6);
        s = {pad.oe_n[18], pad.out[18], pad.pull_up[16], pad.pull_up[19], pad.pull_up[20]};
        chk(32'(s), 32'({1'b0, rnd[0], 3'h7}));
        chk(32'({dbg_rst, dbg_di, dbg_ms}), 32'({rnd[1], rnd[4], rnd[5]}));
        @(posedge pclk);
        sw_mode <= 1'b1;
        swd_drv <= 1'b1;
        swd_o <= rnd[6];
        wt(6);
        chk(32'({pad.oe_n[20], pad.out[20]}), 32'(rnd[6]));
        rdc(8'h34, 32'h8, 32'h8);
        swd_drv <= 1'b0;
        sw_mode <= 1'b0;
        dbg_req <= 1'b1;
        wt(6);
        apb(1'b1, 8'h30, 32'h20);
        rdc(8'h30, 32'h20, 32'h0);
        rdc(8'h34, 32'h4, 32'h4);
        dbg_req <= 1'b0;
        wt(6);
        apb(1'b1, 8'h30, 32'h20);
        rdc(8'h30, 32'h20, 32'h20);
        wt(1);
        chk(32'({pad.oe_n[18], pad.pull_up[16], dbg_rst}), 32'h5);
        @(posedge pclk);
        rst_hold <= 1'b1;
        dbg_req <= 1'b1;
        wt(8);
        @(posedge pclk);
        rst_hold <= 1'b0;
        dbg_req <= 1'b0;
        wt(6);
        rdc(8'h34, 32'h1, 32'h1);
        rdc(8'h30, 32'h20, 32'h0);
        apb(1'b1, 8'h34, 32'h1);
        rdc(8'h34, 32'h1, 32'h0);
        for (int k = 0; k < 21; k++)
        begin
            @(posedge pclk);
            m = modes[k / 3];
            rnd = lfsr(rnd);
            {b, v, e} = rnd[2:0];
            sa_en[13] <= e;
            sa_out[13] <= v;
            brd_en[13] <= (m == 4'h4 || m == 4'h8);
            brd_lvl[13] <= rnd[3];
            brd_pu[13] <= (m == 4'h5 || m == 4'hD);
            apb(1'b1, 8'h0C, 32'({8'h44, m, 4'h4}));
            apb(1'b1, 8'h1C, 32'({b, 5'h0}));
            wt(6);
            s = {pad.analog[13], pad.pull_up[13], pad.pull_dn[13],
                !pad.oe_n[13] & pad.out[13], !pad.oe_n[13] & !pad.out[13]};
            chk(32'(s), 32'(exp_pad(m, b, e & v)));
            rdc(8'h28, 32'h20, 32'(exp_lvl(m, b, e & v, rnd[3])) << 5);
        end
        for (int a = 0; a < 4; a++)
            apb(1'b1, 8'(a * 4), 32'h9999);
        tmr <= 4'hf;
        sa_en <= '1;
        sa_out <= '0;
        for (int k = 0; k < 16; k++)
        begin
            apb(1'b1, 8'h38, 32'(k[1]) << (4 + k[3:2]));
            apb(1'b1, 8'h3C, 32'(k[0]) << k[3:2]);
            wt(1);
            s = 5'(k[1] ? pb[k[3:2]] : pa[k[3:2]]);
            chk(32'(pad.out[15:0] & 16'hff7f), 32'(k[0]) << s);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        do_reset(1'b1);
        conclude();
    end
endmodule : gpcfg_tb_top
